/* File: hdl/emc_pkg.sv */
// Constants, types and address map of the external memory bus controller
package emc_pkg;
  localparam int STATE_CLKS = 2;
  localparam logic [15:0] SFR_LAST = 16'h0017;
  localparam logic [15:0] SP_LAST = 16'h0019;
  localparam logic [15:0] PORT_REBUILD = 16'h1ffe;
  localparam logic [15:0] VEC_FIRST = 16'h2000;
  localparam logic [15:0] VEC_LAST = 16'h2011;
  localparam int VEC_COUNT = 9;
  localparam logic [15:0] CFG_ADDR = 16'h2018;
  localparam logic [15:0] JTS_ADDR = 16'h201a;
  localparam logic [15:0] JTS_OPCODES = 16'hfe27;
  localparam logic [15:0] KEY_FIRST = 16'h2020;
  localparam logic [15:0] KEY_LAST = 16'h202f;
  localparam logic [15:0] RESET_ADDR = 16'h2080;
  localparam logic [15:0] ROM_FIRST = 16'h2000;
  localparam logic [15:0] ROM_LAST = 16'h3fff;
  localparam logic [7:0] RESERVED_FILL = 8'hff;
  localparam logic [7:0] CFG_RESET = 8'hff;
  localparam int QUEUE_DEPTH = 4;
  localparam int RELOAD_STATES = 4;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RELOAD = 5'b00010,
    S_FLUSH = 5'b00100,
    S_ADDR = 5'b01000,
    S_STRB = 5'b10000
  } emc_state_t;
  typedef enum logic [1:0] {
    K_FETCH = 2'h0,
    K_DATA = 2'h1,
    K_CFG = 2'h2
  } emc_kind_t;
endpackage

/* File: hdl/emc_q_if.sv */
// Link between the bus sequencer and its prefetch queue
`timescale 1ns/10ps
interface emc_q_if;
  logic push;
  logic [7:0] wdata;
  logic pop;
  logic [7:0] rdata;
  logic flush;
  logic full;
  logic empty;
  modport ctl(output push, output wdata, output pop, output flush,
    input rdata, input full, input empty);
  modport fifo(input push, input wdata, input pop, input flush,
    output rdata, output full, output empty);
endinterface

/* File: hdl/emc_queue.sv */
// Four-byte instruction prefetch queue
`timescale 1ns/10ps
module emc_queue (
  input wire logic clk,
  input wire logic resetn,
  emc_q_if.fifo q
);
  logic [7:0] mem_reg [emc_pkg::QUEUE_DEPTH];
  logic [1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [2:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  assign do_push = q.push && !q.full;
  assign do_pop = q.pop && !q.empty;
  assign q.full = (cnt_reg == 3'(emc_pkg::QUEUE_DEPTH));
  assign q.empty = (cnt_reg == 3'h0);
  assign q.rdata = mem_reg[rd_reg];

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (q.flush) begin
      wr_next = 2'h0;
      rd_next = 2'h0;
      cnt_next = 3'h0;
    end else begin
      if (do_push) wr_next = wr_reg + 2'h1;
      if (do_pop) rd_next = rd_reg + 2'h1;
      cnt_next = cnt_reg + 3'(do_push) - 3'(do_pop);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= 2'h0;
      rd_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push && !q.flush) begin
      mem_reg[wr_reg] <= q.wdata;
    end
  end

  a_q_depth_bound: assert property (@(posedge clk) disable iff (!resetn)
    cnt_reg <= 3'(emc_pkg::QUEUE_DEPTH)) else $error("queue over depth");
endmodule

/* File: hdl/emc_ctrl.sv */
// Memory controller: address decode, slave PC, prefetch and external bus cycles
`timescale 1ns/10ps
module emc_ctrl #(
  parameter bit HAS_ROM = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_access_sel_n,
  input wire logic [7:0] abus_data,
  input wire logic pc_wr_lo,
  input wire logic pc_wr_hi,
  output logic fetch_kind_valid,
  output logic [7:0] fetch_kind_byte,
  input wire logic fetch_kind_pop,
  input wire logic data_req,
  input wire logic data_wr,
  input wire logic data_word,
  input wire logic [15:0] data_addr,
  input wire logic [15:0] data_wdata,
  output logic [15:0] data_rdata,
  output logic data_done,
  output logic vector_hit,
  output logic key_hit,
  output logic [7:0] chip_config_reg,
  output logic [15:0] rom_addr,
  input wire logic [15:0] rom_data,
  output logic [15:0] mux_addr_data_o,
  output logic mux_addr_data_oe,
  input wire logic [15:0] mux_addr_data_i,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic high_byte_enable_n,
  output logic fetch_kind
);
  localparam int RLD_MIN = 6;
  localparam int RLD_MAX = 10;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  emc_q_if q();
  emc_queue u_queue (
    .clk(clk),
    .resetn(resetn),
    .q(q)
  );

  emc_pkg::emc_state_t state_reg, state_next;
  emc_pkg::emc_kind_t kind_reg, kind_next;
  logic [1:0] st_cnt_reg, st_cnt_next;
  logic tick;
  logic ea_done_reg, ea_done_next, ea_lat_reg, ea_lat_next;
  logic cfg_pend_reg, cfg_pend_next;
  logic [7:0] ccr_reg, ccr_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] pc_lo_reg, pc_lo_next;
  logic [15:0] pc_new_reg, pc_new_next;
  logic reload_reg, reload_next;
  logic [15:0] op_addr_reg, op_addr_next;
  logic [15:0] op_wdata_reg, op_wdata_next;
  logic op_wr_reg, op_wr_next, op_word_reg, op_word_next;
  logic op_int_reg, op_int_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic vec_reg, vec_next, key_reg, key_next;
  logic [15:0] rom_addr_reg, rom_addr_next;
  logic [15:0] ad_o_reg, ad_o_next;
  logic ad_oe_reg, ad_oe_next, ale_reg, ale_next;
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic bhe_n_reg, bhe_n_next, fk_reg, fk_next;
  logic [15:0] src;
  logic [7:0] byte_in;
  logic regfile_hit;

  assign tick = (st_cnt_reg == 2'(emc_pkg::STATE_CLKS - 1));
  assign regfile_hit = (data_addr <= emc_pkg::SP_LAST);
  // Read data source picked at strobe end
  assign src = op_int_reg ? rom_data : mux_addr_data_i;
  // Odd bytes ride the upper lanes
  assign byte_in = op_addr_reg[0] ? src[15:8] : src[7:0];

  assign q.wdata = byte_in;
  assign q.pop = fetch_kind_pop;
  assign q.push = (state_reg == emc_pkg::S_STRB) && tick && (kind_reg == emc_pkg::K_FETCH);
  assign q.flush = (state_reg == emc_pkg::S_RELOAD);
  assign fetch_kind_valid = !q.empty;
  assign fetch_kind_byte = q.rdata;

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    st_cnt_next = tick ? 2'h0 : st_cnt_reg + 2'h1;
    ea_done_next = 1'b1;
    ea_lat_next = ea_lat_reg;
    cfg_pend_next = cfg_pend_reg;
    ccr_next = ccr_reg;
    pc_next = pc_reg;
    pc_lo_next = pc_lo_reg;
    pc_new_next = pc_new_reg;
    reload_next = reload_reg;
    op_addr_next = op_addr_reg;
    op_wdata_next = op_wdata_reg;
    op_wr_next = op_wr_reg;
    op_word_next = op_word_reg;
    op_int_next = op_int_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    vec_next = vec_reg;
    key_next = key_reg;
    rom_addr_next = rom_addr_reg;
    ad_o_next = ad_o_reg;
    ad_oe_next = ad_oe_reg;
    ale_next = ale_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    bhe_n_next = bhe_n_reg;
    fk_next = fk_reg;
    // Select level caught once after reset release
    if (!ea_done_reg) begin
      // High level allows internal program memory
      ea_lat_next = ext_access_sel_n;
    end
    // Reload image built from two internal bus bytes
    if (pc_wr_lo) begin
      pc_lo_next = abus_data;
    end
    if (pc_wr_hi) begin
      pc_new_next = {abus_data, pc_lo_reg};
      reload_next = 1'b1;
    end
    unique case (state_reg)
      emc_pkg::S_IDLE: begin
        if (ea_done_reg && !cfg_pend_reg && data_req && regfile_hit && !done_reg) begin
          // Register file accesses answered without a bus cycle
          rdata_next = 16'h0000;
          done_next = 1'b1;
        end else if (ea_done_reg && tick) begin
          if (cfg_pend_reg) begin
            kind_next = emc_pkg::K_CFG;
            op_addr_next = emc_pkg::CFG_ADDR;
            op_wr_next = 1'b0;
            op_word_next = 1'b0;
            state_next = emc_pkg::S_ADDR;
          end else if (reload_reg) begin
            state_next = emc_pkg::S_RELOAD;
          end else if (data_req && !regfile_hit && !done_reg) begin
            kind_next = emc_pkg::K_DATA;
            op_addr_next = data_addr;
            op_wdata_next = data_wdata;
            op_wr_next = data_wr;
            op_word_next = data_word;
            vec_next = in_range(data_addr, emc_pkg::VEC_FIRST, emc_pkg::VEC_LAST);
            key_next = in_range(data_addr, emc_pkg::KEY_FIRST, emc_pkg::KEY_LAST);
            state_next = emc_pkg::S_ADDR;
          end else if (!q.full) begin
            kind_next = emc_pkg::K_FETCH;
            op_addr_next = pc_reg;
            op_wr_next = 1'b0;
            op_word_next = 1'b0;
            state_next = emc_pkg::S_ADDR;
          end
        end
        if (state_next == emc_pkg::S_ADDR) begin
          op_int_next = HAS_ROM && ea_lat_reg &&
            in_range(op_addr_next, emc_pkg::ROM_FIRST, emc_pkg::ROM_LAST);
          rom_addr_next = op_addr_next;
          if (!op_int_next) begin
            // Latch strobe up with address and high enable
            ale_next = 1'b1;
            ad_o_next = op_addr_next;
            ad_oe_next = 1'b1;
            bhe_n_next = !(op_word_next || op_addr_next[0]);
            // Fetch kind marks instruction fetch address phase
            fk_next = (kind_next == emc_pkg::K_FETCH);
          end
        end
      end
      emc_pkg::S_RELOAD: begin
        // Reload spans two state times before the fetch
        if (tick) begin
          pc_next = pc_new_reg;
          reload_next = pc_wr_hi;
          state_next = emc_pkg::S_FLUSH;
        end
      end
      emc_pkg::S_FLUSH: begin
        if (tick) begin
          kind_next = emc_pkg::K_FETCH;
          op_addr_next = pc_reg;
          op_wr_next = 1'b0;
          op_word_next = 1'b0;
          op_int_next = HAS_ROM && ea_lat_reg &&
            in_range(pc_reg, emc_pkg::ROM_FIRST, emc_pkg::ROM_LAST);
          rom_addr_next = pc_reg;
          if (!op_int_next) begin
            ale_next = 1'b1;
            ad_o_next = pc_reg;
            ad_oe_next = 1'b1;
            bhe_n_next = !pc_reg[0];
            fk_next = 1'b1;
          end
          state_next = emc_pkg::S_ADDR;
        end
      end
      emc_pkg::S_ADDR: begin
        if (tick) begin
          // Latch strobe falls, address leaves the shared pins
          ale_next = 1'b0;
          fk_next = 1'b0;
          if (!op_int_reg) begin
            if (op_wr_reg) begin
              // Write data replaces address as the write strobe falls
              wr_n_next = 1'b0;
              ad_oe_next = 1'b1;
              if (op_word_reg) begin
                ad_o_next = op_wdata_reg;
              end else if (op_addr_reg[0]) begin
                ad_o_next = {op_wdata_reg[7:0], 8'h00};
              end else begin
                ad_o_next = {8'h00, op_wdata_reg[7:0]};
              end
            end else begin
              rd_n_next = 1'b0;
              ad_oe_next = 1'b0;
            end
          end
          state_next = emc_pkg::S_STRB;
        end
      end
      emc_pkg::S_STRB: begin
        if (tick) begin
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          ad_oe_next = 1'b0;
          bhe_n_next = 1'b1;
          state_next = emc_pkg::S_IDLE;
          unique case (kind_reg)
            emc_pkg::K_FETCH: begin
              // Slave PC steps after each fetch
              pc_next = pc_reg + 16'h0001;
            end
            emc_pkg::K_CFG: begin
              // Configuration byte held until next reset
              ccr_next = byte_in;
              cfg_pend_next = 1'b0;
            end
            default: begin
              rdata_next = op_word_reg ? src : {8'h00, byte_in};
              done_next = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= emc_pkg::S_IDLE;
      kind_reg <= emc_pkg::K_FETCH;
      st_cnt_reg <= 2'h0;
      ea_done_reg <= 1'b0;
      ea_lat_reg <= 1'b0;
      cfg_pend_reg <= 1'b1;
      ccr_reg <= emc_pkg::CFG_RESET;
      // Fetching begins at the reset location
      pc_reg <= emc_pkg::RESET_ADDR;
      pc_lo_reg <= 8'h00;
      pc_new_reg <= 16'h0000;
      reload_reg <= 1'b0;
      op_addr_reg <= 16'h0000;
      op_wdata_reg <= 16'h0000;
      op_wr_reg <= 1'b0;
      op_word_reg <= 1'b0;
      op_int_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
      vec_reg <= 1'b0;
      key_reg <= 1'b0;
      rom_addr_reg <= 16'h0000;
      ad_o_reg <= 16'h0000;
      ad_oe_reg <= 1'b0;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      bhe_n_reg <= 1'b1;
      fk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      st_cnt_reg <= st_cnt_next;
      ea_done_reg <= ea_done_next;
      ea_lat_reg <= ea_lat_next;
      cfg_pend_reg <= cfg_pend_next;
      ccr_reg <= ccr_next;
      pc_reg <= pc_next;
      pc_lo_reg <= pc_lo_next;
      pc_new_reg <= pc_new_next;
      reload_reg <= reload_next;
      op_addr_reg <= op_addr_next;
      op_wdata_reg <= op_wdata_next;
      op_wr_reg <= op_wr_next;
      op_word_reg <= op_word_next;
      op_int_reg <= op_int_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      vec_reg <= vec_next;
      key_reg <= key_next;
      rom_addr_reg <= rom_addr_next;
      ad_o_reg <= ad_o_next;
      ad_oe_reg <= ad_oe_next;
      ale_reg <= ale_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      bhe_n_reg <= bhe_n_next;
      fk_reg <= fk_next;
    end
  end

  assign data_rdata = rdata_reg;
  assign data_done = done_reg;
  assign vector_hit = vec_reg;
  assign key_hit = key_reg;
  assign chip_config_reg = ccr_reg;
  assign rom_addr = rom_addr_reg;
  assign mux_addr_data_o = ad_o_reg;
  assign mux_addr_data_oe = ad_oe_reg;
  assign ale = ale_reg;
  assign rd_n = rd_n_reg;
  assign wr_n = wr_n_reg;
  assign high_byte_enable_n = bhe_n_reg;
  assign fetch_kind = fk_reg;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  a_cfg_reg_hold: assert property (!cfg_pend_reg |=> $stable(ccr_reg))
    else $error("config register changed after load");
  a_reset_pc_start: assert property ($fell(cfg_pend_reg) |-> pc_reg == emc_pkg::RESET_ADDR)
    else $error("first fetch not at reset location");
  a_regfile_no_bus: assert property (
    (state_reg == emc_pkg::S_IDLE) && ea_done_reg && !cfg_pend_reg && data_req &&
    regfile_hit && !done_reg |=> data_done && !ale) else $error("regfile access on bus");
  a_ea_latch_hold: assert property (ea_done_reg |=> $stable(ea_lat_reg))
    else $error("select latch moved");
  a_fetch_kind_low: assert property (fetch_kind |-> ale && kind_reg == emc_pkg::K_FETCH)
    else $error("fetch kind high outside fetch address phase");
  a_ale_then_strobe: assert property (
    $fell(ale) |-> (!rd_n && !mux_addr_data_oe) || (!wr_n && mux_addr_data_oe))
    else $error("strobe not after latch fall");
  a_odd_byte_lane: assert property (
    ale && !op_word_reg && op_addr_reg[0] |-> !high_byte_enable_n && mux_addr_data_o[0])
    else $error("odd byte lane select wrong");
  a_int_no_pins: assert property ((state_reg == emc_pkg::S_ADDR) && op_int_reg |-> !ale)
    else $error("internal cycle drove pins");
  a_phase_on_tick: assert property ($changed(state_reg) |-> $past(tick))
    else $error("phase changed off boundary");
  a_pc_step: assert property (q.push && !reload_reg |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("slave counter did not step");
  a_reload_time: assert property (
    $rose(state_reg == emc_pkg::S_RELOAD) |-> ##[RLD_MIN:RLD_MAX] fetch_kind_valid)
    else $error("reload took too long");
  a_rd_low_width: assert property ($fell(rd_n) |-> !rd_n [*2] ##1 rd_n)
    else $error("read strobe width wrong");

  c_cfg_load: cover property ($fell(cfg_pend_reg));
  c_reload: cover property ($rose(state_reg == emc_pkg::S_RELOAD));
  c_ext_write: cover property ($fell(wr_n));
  c_odd_read: cover property ($fell(rd_n) && op_addr_reg[0]);
endmodule

/* File: verif/emc_ext_mem.sv */
// External memory behind a clock-edge address latch, loaded while ale is high, on the multiplexed bus
`timescale 1ns/10ps
module emc_ext_mem (
  input wire logic clk,
  input wire logic [15:0] mux_addr_data_o,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic high_byte_enable_n,
  output logic [15:0] mux_addr_data_i
);
  logic [7:0] mem [0:65535];
  logic [15:0] lat_addr = 16'h0000;
  logic lat_bhe_n = 1'b1;
  logic [15:0] last = 16'h0000;
  logic [15:0] rword;
  logic low_byte_write_n, high_byte_write_n;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
    end
    for (int i = 16'h2012; i <= 16'h207f; i++) begin
      if (i == 16'h2018 || i == 16'h201a || i == 16'h201b) continue;
      if (i >= 16'h2020 && i <= 16'h202f) continue;
      mem[i] = 8'hff;
    end
    mem[16'h201a] = 8'h27;
    mem[16'h201b] = 8'hfe;
  end
  assign rword = {mem[lat_addr | 16'h0001], mem[lat_addr & 16'hfffe]};
  // Lane write strobes from bit 0 and high enable
  assign low_byte_write_n = wr_n | lat_addr[0];
  assign high_byte_write_n = wr_n | lat_bhe_n;
  // Data only while read strobe low
  assign mux_addr_data_i = !rd_n ? rword : ~last;
  always @(posedge clk) begin
    if (ale) begin
      lat_addr <= mux_addr_data_o;
      lat_bhe_n <= high_byte_enable_n;
    end
    if (!rd_n) begin
      last <= rword;
    end
    if (!low_byte_write_n) mem[lat_addr] <= mux_addr_data_o[7:0];
    if (!high_byte_write_n) mem[lat_addr | 16'h0001] <= mux_addr_data_o[15:8];
  end
endmodule

/* File: verif/tb_external_memory_bus_controller.sv */
// Self-checking bench for the external memory bus controller
`timescale 1ns/10ps
module tb_external_memory_bus_controller;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ext_access_sel_n = 1'b0;
  logic [7:0] abus_data = 8'h00;
  logic pc_wr_lo = 1'b0;
  logic pc_wr_hi = 1'b0;
  logic fetch_kind_pop = 1'b0;
  logic data_req = 1'b0;
  logic data_wr = 1'b0;
  logic data_word = 1'b0;
  logic [15:0] data_addr = 16'h0000;
  logic [15:0] data_wdata = 16'h0000;
  logic [15:0] rom_data = 16'h0000;
  logic fetch_kind_valid, data_done, vector_hit, key_hit, ale, rd_n, wr_n;
  logic high_byte_enable_n, fetch_kind, mux_addr_data_oe;
  logic [7:0] fetch_kind_byte, chip_config_reg;
  logic [15:0] data_rdata, rom_addr, mux_addr_data_o, mux_addr_data_i;
  logic [15:0] exp_data [$];
  logic [7:0] exp_fetch_kind [$];
  int fail_count = 0;
  int n_compared = 0;
  int ale_cnt = 0;
  logic fk_exp;
  logic [7:0] ie_exp;

  emc_ctrl i_emc_ctrl (.clk, .resetn, .ext_access_sel_n, .abus_data, .pc_wr_lo, .pc_wr_hi,
    .fetch_kind_valid, .fetch_kind_byte, .fetch_kind_pop, .data_req, .data_wr, .data_word, .data_addr,
    .data_wdata, .data_rdata, .data_done, .vector_hit, .key_hit, .chip_config_reg,
    .rom_addr, .rom_data, .mux_addr_data_o, .mux_addr_data_oe, .mux_addr_data_i, .ale,
    .rd_n, .wr_n, .high_byte_enable_n, .fetch_kind);
  emc_ext_mem i_emc_ext_mem (.clk, .mux_addr_data_o, .ale, .rd_n, .wr_n,
    .high_byte_enable_n, .mux_addr_data_i);

  always #5 clk = ~clk;

  function automatic logic [7:0] extf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] romf(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h11;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (exp_data.size() != 0 || exp_fetch_kind.size() != 0) fail_count++;
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Internal program memory answers on the word holding the address
  always @(negedge clk) begin
    rom_data <= {romf(rom_addr | 16'h0001), romf(rom_addr & 16'hfffe)};
  end

  // Result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (ale === 1'b1) begin
      ale_cnt++;
      fk_exp = !(mux_addr_data_o == 16'h2018 || (data_req && mux_addr_data_o == data_addr));
      check({15'h0000, fetch_kind}, {15'h0000, fk_exp});
    end
    if (data_done === 1'b1 && data_wr === 1'b0) begin
      check(data_rdata, exp_data.size() > 0 ? exp_data.pop_front() : 16'hxxxx);
    end
    if (fetch_kind_pop === 1'b1 && fetch_kind_valid === 1'b1) begin
      ie_exp = exp_fetch_kind.size() > 0 ? exp_fetch_kind.pop_front() : 8'hxx;
      check({8'h00, fetch_kind_byte}, {8'h00, ie_exp});
    end
    if (rd_n === 1'b0) check({15'h0000, mux_addr_data_oe}, 16'h0000);
  end

  task automatic access(input logic wr, input logic word, input logic [15:0] a,
      input logic [15:0] wd, input logic [15:0] exp);
    int n;
    @(negedge clk);
    if (!wr) exp_data.push_back(exp);
    data_req = 1'b1;
    data_wr = wr;
    data_word = word;
    data_addr = a;
    data_wdata = wd;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (data_done !== 1'b1 && n < 200);
    if (n >= 200) fail_count++;
    @(negedge clk);
    data_req = 1'b0;
  endtask

  task automatic pop_run(input logic [15:0] start, input int cnt, input bit rom);
    int n;
    for (int k = 0; k < cnt; k++) begin
      exp_fetch_kind.push_back(rom ? romf(start + 16'(k)) : extf(start + 16'(k)));
    end
    @(negedge clk);
    fetch_kind_pop = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (exp_fetch_kind.size() != 0 && n < 300);
    fetch_kind_pop = 1'b0;
  endtask

  task automatic wait_fetch_kind;
    int n;
    n = 0;
    while (fetch_kind_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    int n;
    logic [15:0] a, w;
    logic [7:0] b;
    void'($urandom(28046));
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    wait_fetch_kind();
    check({8'h00, chip_config_reg}, {8'h00, extf(16'h2018)});
    pop_run(16'h2080, 5, 1'b0);
    repeat (4) begin
      a = {4'h6, 11'($urandom), 1'b0};
      w = 16'($urandom);
      b = 8'($urandom);
      access(1'b1, 1'b1, a, w, 16'h0000);
      access(1'b1, 1'b0, a | 16'h0001, {8'h00, b}, 16'h0000);
      access(1'b0, 1'b1, a, 16'h0000, {b, w[7:0]});
      access(1'b0, 1'b0, a | 16'h0001, 16'h0000, {8'h00, b});
      access(1'b0, 1'b0, a, 16'h0000, {8'h00, w[7:0]});
    end
    access(1'b1, 1'b0, 16'h2018, 16'h0055, 16'h0000);
    check({8'h00, chip_config_reg}, {8'h00, extf(16'h2018)});
    access(1'b0, 1'b1, 16'h2004, 16'h0000, {extf(16'h2005), extf(16'h2004)});
    check({15'h0000, vector_hit}, 16'h0001);
    access(1'b0, 1'b1, 16'h2028, 16'h0000, {extf(16'h2029), extf(16'h2028)});
    check({14'h0000, vector_hit, key_hit}, 16'h0001);
    access(1'b0, 1'b1, 16'h201a, 16'h0000, 16'hfe27);
    access(1'b0, 1'b0, 16'h2019, 16'h0000, 16'h00ff);
    access(1'b1, 1'b0, 16'h1fff, {8'h00, b}, 16'h0000);
    access(1'b0, 1'b1, 16'h1ffe, 16'h0000, {b, extf(16'h1ffe)});
    n = ale_cnt;
    access(1'b0, 1'b0, 16'h0010, 16'h0000, 16'h0000);
    access(1'b1, 1'b1, 16'h0018, 16'h1234, 16'h0000);
    check(16'(ale_cnt - n), 16'h0000);
    b = 8'($urandom);
    @(negedge clk);
    abus_data = b;
    pc_wr_lo = 1'b1;
    @(negedge clk);
    pc_wr_lo = 1'b0;
    abus_data = 8'h50;
    pc_wr_hi = 1'b1;
    @(negedge clk);
    pc_wr_hi = 1'b0;
    n = 1;
    while (fetch_kind_valid !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (fetch_kind_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= 7 && n <= 12), 16'h0001);
    pop_run({8'h50, b}, 6, 1'b0);
    @(negedge clk);
    resetn = 1'b0;
    ext_access_sel_n = 1'b1;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    ext_access_sel_n = 1'b0;
    n = ale_cnt;
    wait_fetch_kind();
    check({8'h00, chip_config_reg}, {8'h00, romf(16'h2018)});
    pop_run(16'h2080, 5, 1'b1);
    check(16'(ale_cnt - n), 16'h0000);
    access(1'b0, 1'b1, 16'h2100, 16'h0000, {romf(16'h2101), romf(16'h2100)});
    repeat (10) @(negedge clk);
    final_report();
  end
endmodule
